// ### pkg/rms_pkg.sv
// Purpose: shared constants for the rms and energy compensation block
// Assumes: 10 MHz master clock, 16-bit signed channel samples
// Notes: register map sits on 32-bit aligned APB words
package rms_pkg;
  localparam int SMP_W = 16;
  localparam int CLK_HZ = 10_000_000;
  // corner of the 90 degree shift filter, in hertz
  localparam int SHIFT90_HZ = 2;
  // one-pole shift giving a corner near CLK_HZ/(2*pi*2^k)
  localparam int LPF90_K = $clog2(CLK_HZ / (6 * SHIFT90_HZ));
  localparam int RMS_K = 16;
  localparam int EN_K = 16;
  localparam int PH_STEP = 8;
  localparam logic [5:0] PH_NEUTRAL = 6'h0d;
  localparam int DLY_AW = 10;
  localparam logic [9:0] DLY_BASE = 10'h200;
  localparam int IOS_K = 15;
  localparam int GAIN_K = 12;
  localparam logic [13:0] GAIN_ONE = 14'h1000;
  localparam logic [4:0] SQRT_LAST = 5'h0f;
  // register byte offsets
  localparam logic [7:0] A_VOLTAGE_RMS_RESULT = 8'h00;
  localparam logic [7:0] A_CURRENT_RMS_RESULT = 8'h04;
  localparam logic [7:0] A_VOS = 8'h08;
  localparam logic [7:0] A_IOS = 8'h0c;
  localparam logic [7:0] A_GAIN = 8'h10;
  localparam logic [7:0] A_DIV = 8'h14;
  localparam logic [7:0] A_AEN = 8'h18;
  localparam logic [7:0] A_LACT = 8'h1c;
  localparam logic [7:0] A_LAPP = 8'h20;
  localparam logic [7:0] A_LREA = 8'h24;
  localparam logic [7:0] A_HCYC = 8'h28;
  localparam logic [7:0] A_PHC = 8'h2c;
  localparam logic [7:0] A_MODE = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  localparam logic [7:0] A_MASK = 8'h38;
  // reset values
  localparam logic [15:0] HCYC_RST = 16'h0064;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // status and mask bit positions
  localparam int ST_ZX = 0;
  localparam int ST_LINE = 1;
  localparam int ST_RMS = 2;
  localparam int ST_W = 3;
  localparam int MODE_LINE = 0;
endpackage

// ### hdl/rms_sqrt.sv
// Purpose: sixteen-step restoring square root of a 32-bit value
// Assumes: start is ignored while busy
// Notes: result holds until the next root is finished
`timescale 1ns/100ps
`default_nettype none
module rms_sqrt
  import rms_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [31:0] radicand_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] root_o
);
  logic [31:0] rad_reg, rad_next, orig_reg, orig_next;
  logic [17:0] rem_reg, rem_next, shifted, trial;
  logic [15:0] root_reg, root_next, res_reg, res_next;
  logic [4:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next, done_reg, done_next;

  // one result bit per clock, two radicand bits consumed each step
  always_comb begin
    rad_next = rad_reg;
    orig_next = orig_reg;
    rem_next = rem_reg;
    root_next = root_reg;
    res_next = res_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    shifted = {rem_reg[15:0], rad_reg[31:30]};
    trial = {root_reg, 2'b01};
    if (busy_reg) begin
      rad_next = {rad_reg[29:0], 2'b00};
      cnt_next = cnt_reg - 5'h01;
      if (shifted >= trial) begin
        rem_next = shifted - trial;
        root_next = {root_reg[14:0], 1'b1};
      end else begin
        rem_next = shifted;
        root_next = {root_reg[14:0], 1'b0};
      end
      if (cnt_reg == '0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        res_next = root_next;
      end
    end else if (start_i) begin
      rad_next = radicand_i;
      orig_next = radicand_i;
      rem_next = '0;
      root_next = '0;
      cnt_next = SQRT_LAST;
      busy_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rad_reg <= '0;
      orig_reg <= '0;
      rem_reg <= '0;
      root_reg <= '0;
      res_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rad_reg <= rad_next;
      orig_reg <= orig_next;
      rem_reg <= rem_next;
      root_reg <= root_next;
      res_reg <= res_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign root_o = res_reg;

  root_bracket_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
    done_reg |-> (34'(res_reg) * 34'(res_reg) <= 34'(orig_reg)) &&
      ((34'(res_reg) + 34'h1) * (34'(res_reg) + 34'h1) > 34'(orig_reg)))
    else $error("square root result out of bracket");
endmodule
`default_nettype wire

// ### hdl/rms_energy_compensation.sv
// Purpose: rms, apparent and line energy compensation datapath
// Assumes: samples come from on-chip converters on clk_i
// Notes: APB slave with zero wait states, one level interrupt
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: rms squares each channel sample in a digital multiplier.
// R2: squared signal is low-pass filtered, its square root is the rms.
// R3: voltage rms offset is added after the filter and square root.
// R4: voltage rms offset is a 12-bit two's complement value.
// R5: current offset times 32768 is added to mean square before root.
// R6: apparent energy is divided by divider, times one plus gain/4096.
// R7: reactive energy exists only in line accumulation mode.
// R8: reactive energy over set half cycles is stored in line register.
// R9: current passes a 2 Hz low-pass giving the 90 degree shift.
// R10: phase cal is signed, 0x0d neutral, correction negates difference.
// R11: interrupt can flag each voltage zero crossing.
// R12: host reads line active and apparent energy after line interrupt.
// R13: voltage delayed by (phase cal - 0x0d) times 8 clocks.
// R14: apparent gain is signed, negative values reduce energy.
module rms_energy_compensation
  import rms_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic signed [15:0] voltage_sample_i,
  input wire logic signed [15:0] current_sample_i,
  output logic irq_o
);
  function automatic logic map_hit(input logic [7:0] a);
    map_hit = (a <= A_MASK) && (a[1:0] == 2'b00);
  endfunction

  // control registers
  logic signed [11:0] vos_reg, vos_next, ios_reg, ios_next;
  logic signed [11:0] gain_reg, gain_next;
  logic [15:0] div_reg, div_next, hcyc_reg, hcyc_next;
  logic [5:0] phase_cal_value_reg, phase_cal_value_next;
  logic mode_reg, mode_next;
  logic [ST_W-1:0] stat_reg, stat_next, mask_reg, mask_next, ev;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next, rmux;
  logic wr;
  // delay line and filters
  logic [31:0] dly_mem [0:(1<<DLY_AW)-1];
  logic [DLY_AW-1:0] wptr_reg, wptr_next, caddr, vaddr, ph_cyc;
  logic fill_reg, fill_next;
  logic signed [6:0] ph_diff;
  logic signed [15:0] volt_reg, volt_next, curr_reg, curr_next, i90;
  logic vsign_reg, vsign_next, zx;
  logic [31:0] vsq, isq, vms_reg, vms_next, ims_reg, ims_next;
  logic signed [36:0] i90_reg, i90_next;
  // rms results and apparent energy
  logic v_busy, v_done, i_done;
  logic [15:0] v_root, i_root;
  logic signed [33:0] irad_s;
  logic [31:0] irad, va;
  logic [23:0] voltage_rms_result_reg, voltage_rms_result_next, current_rms_result_reg, current_rms_result_next;
  logic signed [13:0] gain_f;
  logic signed [46:0] prod;
  logic [33:0] scaled, sum, quot, pre_reg, pre_next;
  logic [15:0] div_eff;
  logic [31:0] aen_reg, aen_next;
  // line accumulation
  logic line_en, line_done;
  logic [15:0] hcnt_reg, hcnt_next;
  logic signed [31:0] p_ins, q_ins;
  logic [31:0] lp_reg, lp_next, lq_reg, lq_next, lva_reg, lva_next;
  logic [31:0] lact_reg, lact_next, lrea_reg, lrea_next;
  logic [31:0] lapp_reg, lapp_next;

  assign line_en = mode_reg;
  assign wr = psel_i && penable_i && pwrite_i;

  // sample delay line: current at fixed age, voltage moved by phase cal
  always_comb begin
    wptr_next = wptr_reg + 10'h001;
    // R10 signed neutral
    ph_diff = {phase_cal_value_reg[5], phase_cal_value_reg} - {1'b0, PH_NEUTRAL};
    // R13 voltage delay
    ph_cyc = DLY_AW'(ph_diff * PH_STEP);
    caddr = wptr_reg - DLY_BASE;
    vaddr = caddr - ph_cyc;
    // cells are not reset: taps read zero until the pointer has wrapped once,
    // so no unknown reaches the filters or the crossing detector
    fill_next = fill_reg | (wptr_reg == '1);
    volt_next = fill_reg ? dly_mem[vaddr][31:16] : '0;
    curr_next = fill_reg ? dly_mem[caddr][15:0] : '0;
    vsign_next = volt_reg[SMP_W-1];
    zx = volt_reg[SMP_W-1] != vsign_reg;
    // R1 squaring multiplier
    vsq = 32'(volt_reg * volt_reg);
    isq = 32'(curr_reg * curr_reg);
    // R2 mean square filter
    vms_next = vms_reg + 32'(($signed({1'b0, vsq}) -
      $signed({1'b0, vms_reg})) >>> RMS_K);
    ims_next = ims_reg + 32'(($signed({1'b0, isq}) -
      $signed({1'b0, ims_reg})) >>> RMS_K);
    // R9 quadrature low-pass
    i90_next = i90_reg + 37'(curr_reg) - (i90_reg >>> LPF90_K);
    i90 = 16'(i90_reg >>> LPF90_K);
  end

  always_ff @(posedge clk_i) begin
    dly_mem[wptr_reg] <= {voltage_sample_i, current_sample_i};
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wptr_reg <= '0;
      fill_reg <= 1'b0;
      volt_reg <= '0;
      curr_reg <= '0;
      vsign_reg <= 1'b0;
      vms_reg <= '0;
      ims_reg <= '0;
      i90_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      fill_reg <= fill_next;
      volt_reg <= volt_next;
      curr_reg <= curr_next;
      vsign_reg <= vsign_next;
      vms_reg <= vms_next;
      ims_reg <= ims_next;
      i90_reg <= i90_next;
    end
  end

  // R5 offset before root
  always_comb begin
    irad_s = $signed({2'b00, ims_reg}) + (34'(ios_reg) <<< IOS_K);
    if (irad_s[33])
      irad = '0;
    else if (irad_s[32])
      irad = '1;
    else
      irad = irad_s[31:0];
  end

  // R2 square roots
  rms_sqrt u_vroot (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(!v_busy),
    .radicand_i(vms_reg),
    .busy_o(v_busy),
    .done_o(v_done),
    .root_o(v_root)
  );

  rms_sqrt u_iroot (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(!v_busy),
    .radicand_i(irad),
    .busy_o(),
    .done_o(i_done),
    .root_o(i_root)
  );

  // rms results, apparent energy scaling and division
  always_comb begin
    voltage_rms_result_next = voltage_rms_result_reg;
    current_rms_result_next = current_rms_result_reg;
    aen_next = aen_reg;
    pre_next = pre_reg;
    va = 32'(v_root) * 32'(i_root);
    // R14 signed gain
    gain_f = $signed(GAIN_ONE) + 14'(gain_reg);
    // R6 gain then divide
    prod = $signed({1'b0, va}) * gain_f;
    scaled = prod[46] ? '0 : 34'(prod >>> GAIN_K);
    div_eff = (div_reg == '0) ? 16'h0001 : div_reg;
    sum = pre_reg + scaled;
    quot = sum / 34'(div_eff);
    if (v_done) begin
      // R3 offset after root
      voltage_rms_result_next = 24'($signed({1'b0, v_root})) + 24'(vos_reg);
      current_rms_result_next = 24'(i_root);
    end
    if (i_done) begin
      aen_next = aen_reg + 32'(quot);
      pre_next = sum % 34'(div_eff);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      voltage_rms_result_reg <= '0;
      current_rms_result_reg <= '0;
      aen_reg <= '0;
      pre_reg <= '0;
    end else begin
      voltage_rms_result_reg <= voltage_rms_result_next;
      current_rms_result_reg <= current_rms_result_next;
      aen_reg <= aen_next;
      pre_reg <= pre_next;
    end
  end

  // line accumulation over a count of half line cycles
  always_comb begin
    p_ins = 32'(volt_reg * curr_reg);
    q_ins = 32'(volt_reg * i90);
    hcnt_next = hcnt_reg;
    lact_next = lact_reg;
    lapp_next = lapp_reg;
    lrea_next = lrea_reg;
    line_done = 1'b0;
    lp_next = lp_reg + 32'(p_ins >>> EN_K);
    lq_next = lq_reg + 32'(q_ins >>> EN_K);
    lva_next = i_done ? lva_reg + 32'(quot) : lva_reg;
    if (!line_en) begin
      // R7 no free reactive
      hcnt_next = '0;
      lp_next = '0;
      lq_next = '0;
      lva_next = '0;
    end else if (zx) begin
      if (hcnt_reg + 16'h0001 >= hcyc_reg) begin
        // R8 store reactive total
        line_done = 1'b1;
        hcnt_next = '0;
        lact_next = lp_reg;
        lapp_next = lva_reg;
        lrea_next = lq_reg;
        lp_next = '0;
        lq_next = '0;
        lva_next = '0;
      end else begin
        hcnt_next = hcnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      hcnt_reg <= '0;
      lp_reg <= '0;
      lq_reg <= '0;
      lva_reg <= '0;
      lact_reg <= '0;
      lapp_reg <= '0;
      lrea_reg <= '0;
    end else begin
      hcnt_reg <= hcnt_next;
      lp_reg <= lp_next;
      lq_reg <= lq_next;
      lva_reg <= lva_next;
      lact_reg <= lact_next;
      lapp_reg <= lapp_next;
      lrea_reg <= lrea_next;
    end
  end

  // APB register file, sticky status and interrupt
  always_comb begin
    vos_next = vos_reg;
    ios_next = ios_reg;
    gain_next = gain_reg;
    div_next = div_reg;
    hcyc_next = hcyc_reg;
    phase_cal_value_next = phase_cal_value_reg;
    mode_next = mode_reg;
    mask_next = mask_reg;
    ev = '0;
    // R11 zero crossing event
    ev[ST_ZX] = zx;
    ev[ST_LINE] = line_done;
    ev[ST_RMS] = v_done;
    stat_next = stat_reg | ev;
    case (paddr_i)
      A_VOLTAGE_RMS_RESULT: rmux = 32'($signed(voltage_rms_result_reg));
      A_CURRENT_RMS_RESULT: rmux = 32'(current_rms_result_reg);
      A_VOS: rmux = 32'(vos_reg);
      A_IOS: rmux = 32'(ios_reg);
      A_GAIN: rmux = 32'(gain_reg);
      A_DIV: rmux = 32'(div_reg);
      A_AEN: rmux = aen_reg;
      A_LACT: rmux = lact_reg;
      A_LAPP: rmux = lapp_reg;
      A_LREA: rmux = lrea_reg;
      A_HCYC: rmux = 32'(hcyc_reg);
      A_PHC: rmux = 32'(phase_cal_value_reg);
      A_MODE: rmux = 32'(mode_reg);
      A_STAT: rmux = 32'(stat_reg);
      A_MASK: rmux = 32'(mask_reg);
      default: rmux = '0;
    endcase
    prdata_next = (psel_i && !penable_i) ? rmux : prdata_reg;
    if (wr) begin
      case (paddr_i)
        // R4 twelve-bit offset
        A_VOS: vos_next = pwdata_i[11:0];
        A_IOS: ios_next = pwdata_i[11:0];
        A_GAIN: gain_next = pwdata_i[11:0];
        A_DIV: div_next = pwdata_i[15:0];
        A_HCYC: hcyc_next = pwdata_i[15:0];
        A_PHC: phase_cal_value_next = pwdata_i[5:0];
        A_MODE: mode_next = pwdata_i[MODE_LINE];
        A_MASK: mask_next = pwdata_i[ST_W-1:0];
        // write one clears, a new event wins
        A_STAT: stat_next = (stat_reg & ~pwdata_i[ST_W-1:0]) | ev;
        default: ;
      endcase
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      vos_reg <= '0;
      ios_reg <= '0;
      gain_reg <= '0;
      div_reg <= DIV_RST;
      hcyc_reg <= HCYC_RST;
      phase_cal_value_reg <= PH_NEUTRAL;
      mode_reg <= 1'b0;
      mask_reg <= '0;
      stat_reg <= '0;
      irq_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      vos_reg <= vos_next;
      ios_reg <= ios_next;
      gain_reg <= gain_next;
      div_reg <= div_next;
      hcyc_reg <= hcyc_next;
      phase_cal_value_reg <= phase_cal_value_next;
      mode_reg <= mode_next;
      mask_reg <= mask_next;
      stat_reg <= stat_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !map_hit(paddr_i);
  assign irq_o = irq_reg;

  ms_rises_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
    (vsq > vms_reg + 32'h0001_0000) |=> (vms_reg > $past(vms_reg)))
    else $error("mean square does not follow square");
  voltage_rms_result_offset_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R3
    v_done |=> voltage_rms_result_reg == 24'($signed({1'b0, $past(v_root)})) +
      24'($past(vos_reg)))
    else $error("voltage rms offset not applied");
  current_rms_result_offset_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
    (ios_reg == '0) |-> irad == ims_reg)
    else $error("current offset alters zero case");
  div_unity_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
    (i_done && gain_reg == '0 && div_eff == 16'h0001 && pre_reg == '0)
      |=> aen_reg == $past(aen_reg) + $past(va))
    else $error("unity scaling changes energy");
  no_reactive_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
    !line_en |=> lq_reg == '0)
    else $error("reactive accumulates outside line mode");
  line_store_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
    line_done |=> lrea_reg == $past(lq_reg) && stat_reg[ST_LINE])
    else $error("line reactive total not stored");
  phase_sign_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
    phase_cal_value_reg[5] |-> ph_diff < 0)
    else $error("phase cal not signed");
  neutral_tap_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
    (phase_cal_value_reg == PH_NEUTRAL) |-> vaddr == caddr)
    else $error("neutral phase cal shifts voltage");
  zx_irq_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
    (zx && mask_reg[ST_ZX] && !wr) |=> stat_reg[ST_ZX] && irq_o)
    else $error("zero crossing not signalled");
  gain_neg_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R14
    gain_reg[11] |-> scaled <= 34'(va))
    else $error("negative gain raises energy");
endmodule
`default_nettype wire

// ### bench/host_model.sv
// Purpose: host controller model issuing APB transfers to the block
// Assumes: pready sampled at rising edge, any number of wait states
// Notes: signals change by non-blocking assignment right after an edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  logic [31:0] rdata;
  logic err;

  // idle bus from time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0;
  end

  // setup, access held until pready, then one idle cycle
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: self-checking bench for the rms and energy compensation block
// Assumes: zero inputs give zero raw rms, crossings from a square wave
// Notes: reset held four cycles, run cut short by a cycle ceiling
`timescale 1ns/100ps
`default_nettype none
module tb
  import rms_pkg::*;
;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic signed [15:0] vsamp, isamp;
  logic wave_on;
  int half_cnt, mismatches, compares, cycles;

  rms_energy_compensation DUT (.clk_i(clk), .nrst_i(nrst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .voltage_sample_i(vsamp),
    .current_sample_i(isamp), .irq_o(irq));

  host_model host (.clk_i(clk), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // square wave voltage, sign flips every 200 clocks
  always @(posedge clk) begin
    if (wave_on) begin
      if (half_cnt == 199) begin
        half_cnt <= 0;
        vsamp <= -vsamp;
      end else begin
        half_cnt <= half_cnt + 1;
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    host.xfer(1'b0, a, 32'h0);
    v = host.rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    host.xfer(1'b1, a, v);
  endtask

  // poll a status event, then clear it by writing one
  task automatic wait_bit(input int b);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    while (s[b] !== 1'b1 && n < 2000) begin
      rd(A_STAT, s);
      n++;
    end
    check("status event", 32'h1, {31'h0, s[b]});
    wr(A_STAT, 32'h1 << b);
  endtask

  task automatic wait_rms();
    repeat (3) wait_bit(ST_RMS);
  endtask

  task automatic t_reset();
    rd(A_HCYC, d);
    check("half_cycle_count", {16'h0, HCYC_RST}, d);
    rd(A_PHC, d);
    check("phase_cal_value", {26'h0, PH_NEUTRAL}, d);
    rd(A_DIV, d);
    check("apparent_divider", 32'h0, d);
    rd(A_MODE, d);
    check("mode", 32'h0, d);
    wr(A_GAIN, 32'h00000f00);
    rd(A_GAIN, d);
    // signed field reads back sign-extended
    check("apparent_gain", 32'hffffff00, d);
    wr(A_PHC, 32'h0000003f);
    rd(A_PHC, d);
    check("phase_cal_value", 32'h0000003f, d);
    wr(A_PHC, {26'h0, PH_NEUTRAL});
  endtask

  task automatic t_refuse();
    host.xfer(1'b1, 8'h3c, 32'h7);
    check("slave error", 32'h1, {31'h0, host.err});
    host.xfer(1'b0, 8'h09, 32'h0);
    check("slave error", 32'h1, {31'h0, host.err});
    check("unmapped read", 32'h0, host.rdata);
    rd(A_MASK, d);
    check("mask", 32'h0, d);
    check("slave error", 32'h0, {31'h0, host.err});
  endtask

  // zero inputs: rms results show offsets alone
  task automatic t_rms();
    repeat (2000) @(posedge clk);
    wr(A_VOS, 32'h064);
    wait_rms();
    rd(A_VOLTAGE_RMS_RESULT, d);
    check("voltage_rms_result", 32'h64, {8'h0, d[23:0]});
    wr(A_VOS, 32'hf9c);
    wait_rms();
    rd(A_VOLTAGE_RMS_RESULT, d);
    check("voltage_rms_result", 32'hffff9c, {8'h0, d[23:0]});
    wr(A_IOS, 32'h2);
    wait_rms();
    rd(A_CURRENT_RMS_RESULT, d);
    check("current_rms_result", 32'h100, d);
    wr(A_IOS, 32'h8);
    wait_rms();
    rd(A_CURRENT_RMS_RESULT, d);
    check("current_rms_result", 32'h200, d);
    wr(A_IOS, 32'hffe);
    wr(A_VOS, 32'h0);
    wait_rms();
    rd(A_CURRENT_RMS_RESULT, d);
    check("current_rms_result", 32'h0, d);
    rd(A_VOLTAGE_RMS_RESULT, d);
    check("voltage_rms_result", 32'h0, {8'h0, d[23:0]});
  endtask

  task automatic t_line();
    vsamp <= 16'sd1000;
    wave_on <= 1'b1;
    repeat (6) wait_bit(ST_ZX);
    rd(A_STAT, d);
    check("line done", 32'h0, {31'h0, d[ST_LINE]});
    rd(A_LREA, d);
    check("line_reactive_energy", 32'h0, d);
    wr(A_HCYC, 32'h3);
    wr(A_MASK, 32'h2);
    wait_bit(ST_ZX);
    wr(A_MODE, 32'h1);
    repeat (2) wait_bit(ST_ZX);
    rd(A_STAT, d);
    check("line done", 32'h0, {31'h0, d[ST_LINE]});
    check("irq", 32'h0, {31'h0, irq});
    wait_bit(ST_ZX);
    rd(A_STAT, d);
    check("line done", 32'h1, {31'h0, d[ST_LINE]});
    check("irq", 32'h1, {31'h0, irq});
    rd(A_LACT, d);
    check("line_active_energy", 32'h0, d);
    rd(A_LAPP, d);
    check("line_apparent_energy", 32'h0, d);
    rd(A_LREA, d);
    check("line_reactive_energy", 32'h0, d);
    wr(A_STAT, 32'h2);
    @(posedge clk);
    check("irq", 32'h0, {31'h0, irq});
    wr(A_MODE, 32'h0);
  endtask

  task automatic t_zx_irq();
    int n;
    n = 0;
    // positive current offset gives the apparent energy path a nonzero root
    wr(A_IOS, 32'h2);
    wait_bit(ST_ZX);
    wr(A_MASK, 32'h1);
    while (irq !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    check("irq", 32'h1, {31'h0, irq});
    wr(A_STAT, 32'h1);
    @(posedge clk);
    check("irq", 32'h0, {31'h0, irq});
    wr(A_MASK, 32'h0);
    wr(A_GAIN, 32'h0);
    repeat (450) @(posedge clk);
    rd(A_STAT, d);
    check("zero crossing", 32'h1, {31'h0, d[ST_ZX]});
    check("irq", 32'h0, {31'h0, irq});
  endtask

  // main sequence
  initial begin
    nrst = 1'b0;
    vsamp = 16'sd0;
    isamp = 16'sd0;
    wave_on = 1'b0;
    half_cnt = 0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_refuse();
    t_rms();
    t_line();
    t_zx_irq();
    print_verdict();
  end
endmodule
`default_nettype wire
